//--- logic/stt_pkg.sv
// Shared constants, types and carriers of the serial test transmitter.
// Assumes a 25 MHz core clock and an AXI4-Lite register bus.
package stt_pkg;

// ==========================================
// Register map (byte offsets)
localparam logic [7:0] OFF_TMR_LD = 8'h40;
localparam logic [7:0] OFF_TMR_CON = 8'h44;
localparam logic [7:0] OFF_KEY0 = 8'h80;
localparam logic [7:0] OFF_CTRL = 8'h84;
localparam logic [7:0] OFF_KEY1 = 8'h88;
localparam logic [2:0][7:0] OFF_DAT = {8'h94, 8'h90, 8'h8C};

// ==========================================
// Fields, keys and reset values
localparam logic [15:0] KEY0_VAL = 16'h0007;
localparam logic [15:0] KEY1_VAL = 16'h00B9;
localparam int unsigned EN_BIT = 0;
localparam int unsigned RST_BIT = 1;
localparam int unsigned CNT_LSB = 2;
localparam int unsigned CNT_MSB = 4;
localparam int unsigned TMR_EN_BIT = 7;
localparam logic [2:0] CNT_MAX = 3'h5;
localparam logic [4:0] CTRL_RST = 5'h00;
localparam logic [15:0] DAT_RST = 16'h0000;
localparam logic [15:0] TMR_LD_RST = 16'h0000;
localparam logic [7:0] TMR_CON_RST = 8'h00;
localparam int unsigned TMR_W = 16;
localparam logic [3:0] FRAME_BITS = 4'hC;
localparam logic PAR_ODD = 1'b0;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

// ==========================================
// States
typedef enum logic [2:0] {
    K_IDLE = 3'b001,
    K_ARMED = 3'b010,
    K_PEND = 3'b100
} stt_key_t;

typedef enum logic [2:0] {
    X_IDLE = 3'b001,
    X_LOAD = 3'b010,
    X_SEND = 3'b100
} stt_xmit_t;

// ==========================================
// Bus carriers
typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
} stt_axil_in_t;

typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
} stt_axil_out_t;

// ==========================================
// Module state
typedef struct packed {
    logic [11:0] sreg;
    logic [3:0] cnt;
    logic busy;
    logic done;
    logic txd;
} stt_shift_st_t;

typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    stt_key_t key;
    logic [15:0] pend;
    logic [4:0] ctrl;
    logic [2:0][15:0] dat;
    logic [5:0] have;
    stt_xmit_t xst;
    logic [2:0] idx;
    logic [15:0] tmr_ld;
    logic [7:0] tmr_con;
    logic load;
    logic clr;
    logic [7:0] byte_q;
} stt_top_st_t;

endpackage

//--- logic/stt_baud_timer.sv
// Reload timer giving a one-cycle overflow pulse per bit time.
// Assumes reload and run come from registers on core_clk.
`timescale 1ns/1ps
module stt_baud_timer #(
    parameter int unsigned TMR_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Settings
    input wire logic run,
    input wire logic [TMR_W-1:0] reload,
    // Overflow
    output logic tick
);

// ==========================================
// Parameter check
if (TMR_W < 2 || TMR_W > 32) begin : g_chk
    $error("TMR_W out of range");
end

typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic tick;
} stt_tmr_st_t;

stt_tmr_st_t s_q;
stt_tmr_st_t s_d;
logic last;

// ==========================================
// Counter
assign last = (reload <= TMR_W'(1)) || (s_q.cnt >= reload - TMR_W'(1));

always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
        s_d.cnt = '0;
    end else if (last) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
    end else begin
        s_d.cnt = s_q.cnt + TMR_W'(1);
    end
end

always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        s_q <= '0;
    end else begin
        s_q <= s_d;
    end
end

assign tick = s_q.tick;

endmodule // stt_baud_timer

//--- logic/stt_frame_shifter.sv
// Shifts one byte out as a framed packet, one bit per tick.
// Assumes load, clr and tick are single-cycle pulses on core_clk.
`timescale 1ns/1ps
module stt_frame_shifter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic tick,
    input wire logic load,
    input wire logic clr,
    input wire logic [7:0] data,
    // Status
    output logic busy,
    output logic done,
    // Line
    output logic txd
);

stt_pkg::stt_shift_st_t s_q;
stt_pkg::stt_shift_st_t s_d;

// ==========================================
// Shifter
always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (clr) begin
        s_d.busy = 1'b0;
        s_d.cnt = 4'h0;
        s_d.txd = 1'b1;
    end else if (load && !s_q.busy) begin
        s_d.sreg = {2'b11, ^data ^ stt_pkg::PAR_ODD, data, 1'b0};
        s_d.cnt = stt_pkg::FRAME_BITS;
        s_d.busy = 1'b1;
    end else if (s_q.busy && tick) begin
        if (s_q.cnt == 4'h0) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
        end else begin
            s_d.txd = s_q.sreg[0];
            s_d.sreg = {1'b1, s_q.sreg[11:1]};
            s_d.cnt = s_q.cnt - 4'h1;
        end
    end
end

always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        s_q <= '{sreg: 12'hFFF, cnt: 4'h0, busy: 1'b0, done: 1'b0, txd: 1'b1};
    end else begin
        s_q <= s_d;
    end
end

assign busy = s_q.busy;
assign done = s_q.done;
assign txd = s_q.txd;

// ==========================================
// Checks
sequence frame_load;
    load && !s_q.busy && !clr;
endsequence

frame_len_a: assert property (@(posedge core_clk) disable iff (!resetn)
    frame_load |=> s_q.busy && s_q.cnt == 4'hC)
    else $error("frame not armed with twelve bits");

start_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.busy && tick && !clr && s_q.cnt == 4'hC) |=> !txd)
    else $error("start bit not low");

stop_bits_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.busy && tick && !clr && s_q.cnt inside {4'h1, 4'h2}) |=> txd)
    else $error("stop bit not high");

idle_mark_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !s_q.busy |-> txd)
    else $error("line not at mark when idle");

endmodule // stt_frame_shifter

//--- logic/stt_top.sv
// Serial test transmitter: keyed control, data words, baud timer.
// Assumes an AXI4-Lite master on core_clk and one output pin.
//
// What this block does
// - Stay idle until all counted bytes written.
// - Control reads differently while sending.
// - Control write needs key 07 then B9.
// - 0x11 sends five bytes, 0x05 two.
// - Packet: start, eight data, parity, two stops.
// - Count field bits 4:2 select 1-6.
// - Word zero first, low byte first.
`timescale 1ns/1ps
module stt_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register bus
    input wire stt_pkg::stt_axil_in_t axil_in,
    output stt_pkg::stt_axil_out_t axil_out,
    // Serial pin
    output logic test_serial_output
);

stt_pkg::stt_top_st_t s_q;
stt_pkg::stt_top_st_t s_d;
logic wr_go;
logic commit;
logic tick;
logic sh_busy;
logic sh_done;
logic [2:0] cnt_code;
logic [2:0] nbytes;
logic [5:0] need;
logic [3:0] st_bits;
logic [15:0] ctrl_rd;

// ==========================================
// Decode
assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
assign commit = wr_go && s_q.awaddr == stt_pkg::OFF_KEY1 && s_q.key == stt_pkg::K_PEND
    && s_q.wdata[15:0] == stt_pkg::KEY1_VAL;
assign cnt_code = s_q.ctrl[stt_pkg::CNT_MSB:stt_pkg::CNT_LSB];
assign nbytes = (cnt_code > stt_pkg::CNT_MAX) ? 3'h6 : cnt_code + 3'h1;
assign need = 6'((7'h01 << nbytes) - 7'h01);
assign st_bits = (s_q.xst == stt_pkg::X_IDLE) ? 4'h0 : {1'b0, s_q.idx + 3'h1};
assign ctrl_rd = {7'h00, st_bits, s_q.ctrl};

// ==========================================
// Next state
always_comb begin
    logic hit;
    hit = 1'b0;
    s_d = s_q;
    s_d.load = 1'b0;
    s_d.clr = 1'b0;

    // Transmit sequencer
    case (s_q.xst)
        stt_pkg::X_IDLE: begin
            if (s_q.ctrl[stt_pkg::EN_BIT] && (s_q.have & need) == need
                && !s_q.clr && !sh_busy) begin
                s_d.xst = stt_pkg::X_LOAD;
                s_d.idx = 3'h0;
            end
        end
        stt_pkg::X_LOAD: begin
            s_d.load = 1'b1;
            s_d.byte_q = s_q.idx[0] ? s_q.dat[s_q.idx[2:1]][15:8]
                : s_q.dat[s_q.idx[2:1]][7:0];
            s_d.xst = stt_pkg::X_SEND;
        end
        stt_pkg::X_SEND: begin
            if (sh_done) begin
                if (s_q.idx == nbytes - 3'h1) begin
                    s_d.xst = stt_pkg::X_IDLE;
                    s_d.have = 6'h00;
                end else begin
                    s_d.idx = s_q.idx + 3'h1;
                    s_d.xst = stt_pkg::X_LOAD;
                end
            end
        end
        default: begin
            s_d.xst = stt_pkg::X_IDLE;
        end
    endcase

    // Write channels
    if (axil_in.awvalid && !s_q.aw_got && !s_q.bvalid) begin
        s_d.aw_got = 1'b1;
        s_d.awaddr = axil_in.awaddr;
    end
    if (axil_in.wvalid && !s_q.w_got && !s_q.bvalid) begin
        s_d.w_got = 1'b1;
        s_d.wdata = axil_in.wdata;
        s_d.wstrb = axil_in.wstrb;
    end
    if (s_q.bvalid && axil_in.bready) begin
        s_d.bvalid = 1'b0;
    end

    // Register writes
    if (wr_go) begin
        s_d.aw_got = 1'b0;
        s_d.w_got = 1'b0;
        s_d.bvalid = 1'b1;
        s_d.bresp = stt_pkg::RESP_OKAY;
        s_d.key = stt_pkg::K_IDLE;
        for (int i = 0; i < 3; i++) begin
            if (s_q.awaddr == stt_pkg::OFF_DAT[i]) begin
                hit = 1'b1;
                if (s_q.wstrb[0]) begin
                    s_d.dat[i][7:0] = s_q.wdata[7:0];
                    s_d.have[2*i] = 1'b1;
                end
                if (s_q.wstrb[1]) begin
                    s_d.dat[i][15:8] = s_q.wdata[15:8];
                    s_d.have[2*i+1] = 1'b1;
                end
            end
        end
        case (s_q.awaddr)
            stt_pkg::OFF_KEY0: begin
                if (s_q.wdata[15:0] == stt_pkg::KEY0_VAL) begin
                    s_d.key = stt_pkg::K_ARMED;
                end
            end
            stt_pkg::OFF_CTRL: begin
                if (s_q.key == stt_pkg::K_ARMED) begin
                    s_d.key = stt_pkg::K_PEND;
                    s_d.pend = s_q.wdata[15:0];
                end
            end
            stt_pkg::OFF_KEY1: begin
                if (commit) begin
                    s_d.ctrl = s_q.pend[stt_pkg::RST_BIT] ? stt_pkg::CTRL_RST
                        : s_q.pend[4:0];
                    s_d.have = 6'h00;
                    s_d.xst = stt_pkg::X_IDLE;
                    s_d.clr = 1'b1;
                end
            end
            stt_pkg::OFF_TMR_LD: begin
                s_d.tmr_ld = s_q.wdata[15:0];
            end
            stt_pkg::OFF_TMR_CON: begin
                s_d.tmr_con = s_q.wdata[7:0];
            end
            default: begin
                if (!hit) begin
                    s_d.bresp = stt_pkg::RESP_SLVERR;
                end
            end
        endcase
    end

    // Read channel
    if (s_q.rvalid && axil_in.rready) begin
        s_d.rvalid = 1'b0;
    end
    if (axil_in.arvalid && !s_q.rvalid) begin
        s_d.rvalid = 1'b1;
        s_d.rresp = stt_pkg::RESP_OKAY;
        s_d.rdata = 32'h0000_0000;
        case (axil_in.araddr)
            stt_pkg::OFF_CTRL: s_d.rdata = {16'h0000, ctrl_rd};
            stt_pkg::OFF_DAT[0]: s_d.rdata = {16'h0000, s_q.dat[0]};
            stt_pkg::OFF_DAT[1]: s_d.rdata = {16'h0000, s_q.dat[1]};
            stt_pkg::OFF_DAT[2]: s_d.rdata = {16'h0000, s_q.dat[2]};
            stt_pkg::OFF_TMR_LD: s_d.rdata = {16'h0000, s_q.tmr_ld};
            stt_pkg::OFF_TMR_CON: s_d.rdata = {24'h000000, s_q.tmr_con};
            stt_pkg::OFF_KEY0: s_d.rdata = 32'h0000_0000;
            stt_pkg::OFF_KEY1: s_d.rdata = 32'h0000_0000;
            default: s_d.rresp = stt_pkg::RESP_SLVERR;
        endcase
    end
end

// ==========================================
// State register
always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        s_q <= '0;
        s_q.key <= stt_pkg::K_IDLE;
        s_q.xst <= stt_pkg::X_IDLE;
        s_q.ctrl <= stt_pkg::CTRL_RST;
        s_q.dat <= {3{stt_pkg::DAT_RST}};
        s_q.tmr_ld <= stt_pkg::TMR_LD_RST;
        s_q.tmr_con <= stt_pkg::TMR_CON_RST;
    end else begin
        s_q <= s_d;
    end
end

assign axil_out = '{
    awready: !s_q.aw_got && !s_q.bvalid,
    wready: !s_q.w_got && !s_q.bvalid,
    bvalid: s_q.bvalid,
    bresp: s_q.bresp,
    arready: !s_q.rvalid,
    rvalid: s_q.rvalid,
    rdata: s_q.rdata,
    rresp: s_q.rresp
};

// ==========================================
// Bit timer and shifter
stt_baud_timer #(
    .TMR_W(stt_pkg::TMR_W)
) u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(s_q.tmr_con[stt_pkg::TMR_EN_BIT]),
    .reload(s_q.tmr_ld),
    .tick(tick)
);

stt_frame_shifter u_shift (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick),
    .load(s_q.load),
    .clr(s_q.clr),
    .data(s_q.byte_q),
    .busy(sh_busy),
    .done(sh_done),
    .txd(test_serial_output)
);

// ==========================================
// Checks
sequence load_second;
    s_q.xst == stt_pkg::X_LOAD && s_q.idx == 3'h1 && !commit;
endsequence

idle_until_full_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.xst == stt_pkg::X_LOAD && s_q.idx == 3'h0) |-> ((s_q.have & need) == need))
    else $error("sending before bytes written");

busy_readback_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.xst == stt_pkg::X_IDLE) == (ctrl_rd == {11'h000, s_q.ctrl}))
    else $error("control readback wrong for state");

key_guard_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.ctrl != $past(s_q.ctrl)) |-> $past(commit))
    else $error("control changed without key sequence");

ctrl_decode_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (commit && s_q.pend == 16'h0011) |=> s_q.ctrl[0] && nbytes == 3'h5)
    else $error("0x11 not five bytes enabled");

count_end_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.xst == stt_pkg::X_SEND && sh_done && !wr_go && s_q.idx == nbytes - 3'h1)
    |=> s_q.xst == stt_pkg::X_IDLE && s_q.have == 6'h00)
    else $error("transfer did not end at byte count");

byte_order_a: assert property (@(posedge core_clk) disable iff (!resetn)
    load_second |=> s_q.load && s_q.byte_q == $past(s_q.dat[0][15:8]))
    else $error("second byte not word zero high");

endmodule // stt_top

//--- testbench/stt_rx_model.sv
// Receiver model of the test equipment on the serial pin.
// Assumes the line idles high and BIT core cycles per bit.
`timescale 1ns/1ps
module stt_rx_model #(
    parameter int BIT = 8
) (
    // Clock and line
    input wire logic core_clk,
    input wire logic line,
    // Received bytes
    output logic [7:0] rx_byte,
    output logic rx_stb,
    output logic [7:0] n_bad
);
    logic [11:0] f;
    // ==========================================
    // Frame capture, mid-bit sampling
    initial begin
        rx_byte = 8'h00;
        rx_stb = 1'b0;
        n_bad = 8'h00;
        f = 12'h000;
        forever begin
            @(negedge core_clk);
            if (line === 1'b0) begin
                repeat (BIT / 2) @(negedge core_clk);
                f[0] = line;
                for (int i = 1; i < 12; i++) begin
                    repeat (BIT) @(negedge core_clk);
                    f[i] = line;
                end
                // Start low, even parity, two stops high
                if (f[0] !== 1'b0 || (^f[9:1]) !== 1'b0 || f[11:10] !== 2'b11) begin
                    n_bad = n_bad + 8'h01;
                end
                rx_byte = f[8:1];
                rx_stb = 1'b1;
                @(negedge core_clk);
                rx_stb = 1'b0;
            end
        end
    end
endmodule // stt_rx_model

//--- testbench/stt_top_tb.sv
// Self-checking bench of the serial test transmitter.
// Assumes the receiver model on the pin and an AXI4-Lite master here.
`timescale 1ns/1ps
module stt_top_tb;
    localparam int BIT = 8;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    stt_pkg::stt_axil_in_t bi = '0;
    stt_pkg::stt_axil_out_t ao;
    stt_pkg::stt_axil_out_t ao_s;
    logic line;
    logic [7:0] rx_byte;
    logic [7:0] n_bad;
    logic rx_stb;
    logic [7:0] q[$];
    logic [31:0] seed = 32'h8145;
    logic [31:0] rdat;
    logic [1:0] resp;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    always @(negedge core_clk) ao_s <= ao;
    always @(posedge core_clk) if (rx_stb === 1'b1) q.push_back(rx_byte);

    stt_top stt_top_inst (.core_clk(core_clk), .resetn(resetn), .axil_in(bi), .axil_out(ao),
        .test_serial_output(line));
    stt_rx_model #(.BIT(BIT)) stt_rx_model_inst (.core_clk(core_clk), .line(line),
        .rx_byte(rx_byte), .rx_stb(rx_stb), .n_bad(n_bad));

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_byte(input logic [2:0][15:0] w, input int i);
        return (i % 2 == 1) ? w[i / 2][15:8] : w[i / 2][7:0];
    endfunction
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic tmo(input string what);
        n_errors++;
        $display("ERROR %s wait ran out", what);
        conclude();
    endtask

    // ==========================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        bi.awvalid <= 1'b1;
        bi.awaddr <= a;
        bi.wvalid <= 1'b1;
        bi.wdata <= d;
        bi.wstrb <= 4'hF;
        bi.bready <= 1'b1;
        n = 0;
        forever begin
            @(posedge core_clk);
            n++;
            if (ao_s.awready === 1'b1) bi.awvalid <= 1'b0;
            if (ao_s.wready === 1'b1) bi.wvalid <= 1'b0;
            if (ao_s.bvalid === 1'b1) begin
                resp = ao_s.bresp;
                bi.bready <= 1'b0;
                break;
            end
            if (n > 40) tmo("write");
        end
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge core_clk);
        bi.arvalid <= 1'b1;
        bi.araddr <= a;
        bi.rready <= 1'b1;
        n = 0;
        forever begin
            @(posedge core_clk);
            n++;
            if (ao_s.arready === 1'b1) bi.arvalid <= 1'b0;
            if (ao_s.rvalid === 1'b1) begin
                rdat = ao_s.rdata;
                resp = ao_s.rresp;
                bi.rready <= 1'b0;
                break;
            end
            if (n > 40) tmo("read");
        end
    endtask
    task automatic commit(input logic [15:0] k0, input logic [4:0] c, input logic [15:0] k1,
        input bit mid);
        wr(stt_pkg::OFF_KEY0, {16'h0000, k0});
        if (mid) wr(stt_pkg::OFF_TMR_LD, 32'(BIT));
        wr(stt_pkg::OFF_CTRL, {27'h0, c});
        wr(stt_pkg::OFF_KEY1, {16'h0000, k1});
    endtask

    // ==========================================
    // One transfer of code c with random data
    task automatic send(input logic [2:0] c);
        logic [2:0][15:0] w;
        logic [4:0] ctl;
        int nb;
        int n;
        int t0;
        ctl = {c, 2'b01};
        nb = int'(c) + 1;
        w = '0;
        commit(stt_pkg::KEY0_VAL, ctl, stt_pkg::KEY1_VAL, 1'b0);
        rd(stt_pkg::OFF_CTRL);
        chk("ctrl", {27'h0, ctl}, rdat);
        q.delete();
        for (int i = 0; i < (nb + 1) / 2; i++) begin
            w[i] = 16'(rnd());
            if (i == (nb - 1) / 2) begin
                repeat (3 * BIT * 13) @(posedge core_clk);
                chk("early bytes", 32'h0, 32'(q.size()));
                chk("idle line", 32'h1, {31'h0, line});
            end
            wr(stt_pkg::OFF_DAT[i], {16'h0000, w[i]});
        end
        t0 = cyc;
        rd(stt_pkg::OFF_CTRL);
        chk("ctrl differs", 32'h1, 32'(rdat !== {27'h0, ctl}));
        n = 0;
        do begin
            rd(stt_pkg::OFF_CTRL);
            n++;
        end while (rdat !== {27'h0, ctl} && n < 400);
        if (n == 400) tmo("poll");
        n = cyc - t0;
        chk("drain time", 32'h1, 32'(n >= 13*nb*BIT - BIT && n <= 13*nb*BIT + 2*BIT));
        repeat (2 * BIT) @(posedge core_clk);
        chk("byte count", 32'(nb), 32'(q.size()));
        for (int i = 0; i < nb; i++) begin
            chk("byte", {24'h0, exp_byte(w, i)}, {24'h0, q[i]});
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        chk("line reset", 32'h1, {31'h0, line});
        rd(stt_pkg::OFF_CTRL);
        chk("ctrl reset", 32'h0, rdat);
        rd(stt_pkg::OFF_DAT[0]);
        chk("data reset", 32'h0, rdat);
        wr(stt_pkg::OFF_TMR_LD, 32'(BIT));
        wr(stt_pkg::OFF_TMR_CON, 32'h0000_00C0);
        chk("write resp", {30'h0, stt_pkg::RESP_OKAY}, {30'h0, resp});
        for (int i = 0; i < 3; i++) begin
            commit((i == 0) ? 16'h0006 : stt_pkg::KEY0_VAL, 5'h11,
                (i == 1) ? 16'h00B8 : stt_pkg::KEY1_VAL, i == 2);
            rd(stt_pkg::OFF_CTRL);
            chk("ctrl locked", 32'h0, rdat);
        end
        for (int c = 0; c < 6; c++) send(3'(c));
        chk("frame faults", 32'h0, {24'h0, n_bad});
        commit(stt_pkg::KEY0_VAL, 5'h05, stt_pkg::KEY1_VAL, 1'b0);
        wr(stt_pkg::OFF_DAT[0], {16'h0000, 16'(rnd())});
        repeat (BIT * 20) @(posedge core_clk);
        commit(stt_pkg::KEY0_VAL, 5'h00, stt_pkg::KEY1_VAL, 1'b0);
        rd(stt_pkg::OFF_CTRL);
        chk("ctrl off", 32'h0, rdat);
        repeat (BIT * 13) @(posedge core_clk);
        q.delete();
        for (int i = 0; i < 3; i++) wr(stt_pkg::OFF_DAT[i], rnd());
        repeat (BIT * 40) @(posedge core_clk);
        chk("off bytes", 32'h0, 32'(q.size()));
        chk("off line", 32'h1, {31'h0, line});
        commit(stt_pkg::KEY0_VAL, 5'h05, stt_pkg::KEY1_VAL, 1'b0);
        rd(stt_pkg::OFF_CTRL);
        chk("ctrl two", 32'h5, rdat);
        commit(stt_pkg::KEY0_VAL, 5'h07, stt_pkg::KEY1_VAL, 1'b0);
        rd(stt_pkg::OFF_CTRL);
        chk("ctrl clear", 32'h0, rdat);
        wr(8'hF0, 32'h0);
        chk("unmapped wr", {30'h0, stt_pkg::RESP_SLVERR}, {30'h0, resp});
        rd(8'hF0);
        chk("unmapped", {30'h0, stt_pkg::RESP_SLVERR}, {30'h0, resp});
        conclude();
    end
endmodule // stt_top_tb
